//--- logic/smcl_pkg.sv
// Package for the strap mode configuration latch.
// Assumes one 100 MHz core clock and an internal byte-wide register port.
package smcl_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SMCL_OFS_BRIDGE_CONTROL = 8'h4f;
	localparam logic [7:0] SMCL_OFS_BRIDGE_CONFIG = 8'h54;
	localparam logic [7:0] SMCL_OFS_LINK_MODE = 8'h5b;
	localparam logic [7:0] SMCL_OFS_REMOTE_ADDR = 8'h5f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SMCL_BIT_ID_SOURCE = 0;
	localparam int SMCL_BIT_AUX_AUDIO = 1;
	localparam int SMCL_BIT_REMOTE_COPY = 5;
	localparam int SMCL_BIT_EXT_CTRL = 7;
	localparam int SMCL_BIT_CABLE = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SMCL_RST_BRIDGE_CONTROL = 8'h00;
	localparam logic [7:0] SMCL_RST_BRIDGE_CONFIG = 8'h00;
	localparam logic [7:0] SMCL_RST_LINK_MODE = 8'h00;
	localparam logic [7:0] SMCL_RST_REMOTE_ADDR = 8'ha0;
	localparam logic [7:0] SMCL_RDATA_UNMAPPED = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SMCL_CLK_PERIOD_PS = 10000;
	localparam int SMCL_SETTLE_NS = 2000;
	localparam int SMCL_SETTLE_CYC_RAW =
		(SMCL_SETTLE_NS * 1000 + SMCL_CLK_PERIOD_PS - 1) / SMCL_CLK_PERIOD_PS;
	localparam int SMCL_SETTLE_CYC =
		(SMCL_SETTLE_CYC_RAW < 1) ? 1 : SMCL_SETTLE_CYC_RAW;
	localparam int SMCL_CNT_W = 12;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SMCL_ST_SETTLE = 3'b001,
		SMCL_ST_SAMPLE = 3'b010,
		SMCL_ST_RUN = 3'b100
	} smcl_state_e;

	typedef struct packed {
		smcl_state_e state;
		logic [SMCL_CNT_W-1:0] cnt;
		logic [1:0] sel0_meta;
		logic [1:0] sel0_sync;
		logic [2:0] sel1_meta;
		logic [2:0] sel1_sync;
		logic [7:0] bridge_control;
		logic [7:0] bridge_configuration;
		logic [7:0] link_mode_control;
		logic [7:0] remote_addr;
		logic [7:0] rdata;
		logic done;
	} smcl_state_s;

endpackage : smcl_pkg

//--- logic/smcl_top.sv
// Strap mode configuration latch: samples two multi-level straps once
// after reset, decodes them into five settings and holds them in
// software-visible register bits.
// Assumes the strap comparators deliver a level index per strap and an
// internal register port on the core clock.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Sample, decode, latch both straps after power-up
// - First strap: four levels give two bits
// - Second strap: level n gives n minus one
// - Source 0: remote search, SRAM fallback, overridable
// - Remote read address defaults 0xA0, software replaceable
// - Source 1: use external local display ID
// - Aux audio 0 video-only, 1 adds aux channel
// - Override 1 hands control to external controller
// - Cable type 0 twisted pair, 1 cable_type_select
// - Remote copy 1 copies remote ID into SRAM
// - Source setting latched at bridge control bit 0
// - Aux audio latched at bridge configuration bit 1
// - Override latched at bridge configuration bit 7
// - Cable type latched at link mode bit 7
// - Remote copy latched at bridge configuration bit 5
// - Software reads and rewrites every strapped bit
module smcl_top #(
	parameter int SETTLE_CYC = smcl_pkg::SMCL_SETTLE_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [1:0] MODE_SEL0_LEVEL,
	input wire logic [2:0] MODE_SEL1_LEVEL,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic STRAP_DONE,
	output logic DISPLAY_ID_SOURCE,
	output logic AUX_AUDIO_EN,
	output logic EXTERNAL_CONTROL_OVERRIDE,
	output logic CABLE_TYPE_SELECT,
	output logic REMOTE_DISPLAY_ID_COPY,
	output logic [7:0] REMOTE_ID_ADDR
);
	import smcl_pkg::*;

	localparam logic [SMCL_CNT_W-1:0] SETTLE_LAST =
		SMCL_CNT_W'(SETTLE_CYC - 1);

	smcl_state_s cur_r;
	smcl_state_s cur_nxt;

	// ----------------------------------------------------------------
	// Strap decode
	// ----------------------------------------------------------------
	// Level index k (0 based) stands for printed level k+1, whose value is
	// k: the same mapping for both straps, only the width differs.
	function automatic logic [2:0] strap_value(input logic [2:0] level_idx);
		strap_value = level_idx;
	endfunction : strap_value

	// ----------------------------------------------------------------
	// Offset decode
	// ----------------------------------------------------------------
	// Shared by the write and the read path so both agree on the map
	function automatic logic [3:0] reg_select(input logic [7:0] ofs);
		if (ofs == SMCL_OFS_BRIDGE_CONTROL) begin
			reg_select = 4'h1;
		end else if (ofs == SMCL_OFS_BRIDGE_CONFIG) begin
			reg_select = 4'h2;
		end else if (ofs == SMCL_OFS_LINK_MODE) begin
			reg_select = 4'h4;
		end else if (ofs == SMCL_OFS_REMOTE_ADDR) begin
			reg_select = 4'h8;
		end else begin
			reg_select = 4'h0;
		end
	endfunction : reg_select

	logic [2:0] sel0_val;
	logic [2:0] sel1_val;
	logic [3:0] reg_hit;

	always_comb begin
		sel0_val = strap_value({1'b0, cur_r.sel0_sync});
		sel1_val = strap_value(cur_r.sel1_sync);
		reg_hit = reg_select(REG_ADDR);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		cur_nxt = cur_r;
		// Level indices arrive from analog comparators, so synchronise
		cur_nxt.sel0_meta = MODE_SEL0_LEVEL;
		cur_nxt.sel0_sync = cur_r.sel0_meta;
		cur_nxt.sel1_meta = MODE_SEL1_LEVEL;
		cur_nxt.sel1_sync = cur_r.sel1_meta;

		case (cur_r.state)
			SMCL_ST_SETTLE: begin
				// Lets the divider voltage and the synchroniser settle
				if (cur_r.cnt == SETTLE_LAST) begin
					cur_nxt.state = SMCL_ST_SAMPLE;
				end else begin
					cur_nxt.cnt = cur_r.cnt + 1'b1;
				end
			end
			SMCL_ST_SAMPLE: begin
				// Single capture; later strap movement is ignored
				cur_nxt.bridge_control[SMCL_BIT_ID_SOURCE] =
					sel0_val[1];
				cur_nxt.bridge_configuration[SMCL_BIT_AUX_AUDIO] =
					sel0_val[0];
				cur_nxt.bridge_configuration[SMCL_BIT_EXT_CTRL] =
					sel1_val[2];
				cur_nxt.link_mode_control[SMCL_BIT_CABLE] =
					sel1_val[1];
				cur_nxt.bridge_configuration[SMCL_BIT_REMOTE_COPY] =
					sel1_val[0];
				cur_nxt.done = 1'b1;
				cur_nxt.state = SMCL_ST_RUN;
			end
			SMCL_ST_RUN: begin
				cur_nxt.state = SMCL_ST_RUN;
			end
			default: begin
				cur_nxt.state = SMCL_ST_SETTLE;
			end
		endcase

		// Write follows the capture so a write in the sample cycle wins
		if (REG_WR) begin
			if (reg_hit[0]) begin
				cur_nxt.bridge_control = REG_WDATA;
			end else if (reg_hit[1]) begin
				cur_nxt.bridge_configuration = REG_WDATA;
			end else if (reg_hit[2]) begin
				cur_nxt.link_mode_control = REG_WDATA;
			end else if (reg_hit[3]) begin
				cur_nxt.remote_addr = REG_WDATA;
			end
		end

		if (REG_RD) begin
			if (reg_hit[0]) begin
				cur_nxt.rdata = cur_r.bridge_control;
			end else if (reg_hit[1]) begin
				cur_nxt.rdata = cur_r.bridge_configuration;
			end else if (reg_hit[2]) begin
				cur_nxt.rdata = cur_r.link_mode_control;
			end else if (reg_hit[3]) begin
				cur_nxt.rdata = cur_r.remote_addr;
			end else begin
				cur_nxt.rdata = SMCL_RDATA_UNMAPPED;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cur_r.state <= SMCL_ST_SETTLE;
			cur_r.cnt <= '0;
			cur_r.sel0_meta <= 2'h0;
			cur_r.sel0_sync <= 2'h0;
			cur_r.sel1_meta <= 3'h0;
			cur_r.sel1_sync <= 3'h0;
			cur_r.bridge_control <= SMCL_RST_BRIDGE_CONTROL;
			cur_r.bridge_configuration <= SMCL_RST_BRIDGE_CONFIG;
			cur_r.link_mode_control <= SMCL_RST_LINK_MODE;
			cur_r.remote_addr <= SMCL_RST_REMOTE_ADDR;
			cur_r.rdata <= SMCL_RDATA_UNMAPPED;
			cur_r.done <= 1'b0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the register bits
	// ----------------------------------------------------------------
	// Consumers act on these levels: source 0 means search remote then
	// fall back to SRAM, 1 means external local ID.
	assign DISPLAY_ID_SOURCE =
		cur_r.bridge_control[SMCL_BIT_ID_SOURCE];
	assign AUX_AUDIO_EN =
		cur_r.bridge_configuration[SMCL_BIT_AUX_AUDIO];
	assign EXTERNAL_CONTROL_OVERRIDE =
		cur_r.bridge_configuration[SMCL_BIT_EXT_CTRL];
	assign CABLE_TYPE_SELECT =
		cur_r.link_mode_control[SMCL_BIT_CABLE];
	assign REMOTE_DISPLAY_ID_COPY =
		cur_r.bridge_configuration[SMCL_BIT_REMOTE_COPY];
	assign REMOTE_ID_ADDR = cur_r.remote_addr;
	assign REG_RDATA = cur_r.rdata;
	assign STRAP_DONE = cur_r.done;

endmodule : smcl_top

`default_nettype wire

//--- dv/smcl_checker.sv
// Port-level assertions for the strap mode configuration latch.
// Assumes binding to smcl_top with the same settle parameter.
`timescale 1ns/1ps
`default_nettype none
module smcl_checker #(
	parameter int SETTLE_CYC = smcl_pkg::SMCL_SETTLE_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [1:0] MODE_SEL0_LEVEL,
	input wire logic [2:0] MODE_SEL1_LEVEL,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic STRAP_DONE,
	input wire logic DISPLAY_ID_SOURCE,
	input wire logic AUX_AUDIO_EN,
	input wire logic EXTERNAL_CONTROL_OVERRIDE,
	input wire logic CABLE_TYPE_SELECT,
	input wire logic REMOTE_DISPLAY_ID_COPY,
	input wire logic [7:0] REMOTE_ID_ADDR
);
	logic [7:0] cnt_r;
	logic [7:0] wd_r;
	// Saturating edge count since release pins the capture moment
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) cnt_r <= 8'h00;
		else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
	end
	always_ff @(posedge CORE_CLK) wd_r <= REG_WDATA;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// Capture lands one edge after the last settle count
	AST_DONE_TIME: assert property (STRAP_DONE == (cnt_r >= SETTLE_CYC + 1))
		else $error("strap capture at wrong cycle");
	AST_DONE_HOLD: assert property (STRAP_DONE |=> STRAP_DONE)
		else $error("strap done dropped");
	AST_DECODE: assert property ($rose(STRAP_DONE) && !$past(REG_WR) |->
		{DISPLAY_ID_SOURCE, AUX_AUDIO_EN} == $past(MODE_SEL0_LEVEL, 2) &&
		{EXTERNAL_CONTROL_OVERRIDE, CABLE_TYPE_SELECT, REMOTE_DISPLAY_ID_COPY}
		== $past(MODE_SEL1_LEVEL, 2)) else $error("strap decode wrong");
	AST_WR_CTL: assert property (REG_WR && REG_ADDR == 8'h4f |-> ##1
		DISPLAY_ID_SOURCE == wd_r[0]) else $error("source bit write lost");
	AST_WR_CFG: assert property (REG_WR && REG_ADDR == 8'h54 |=>
		{EXTERNAL_CONTROL_OVERRIDE, REMOTE_DISPLAY_ID_COPY, AUX_AUDIO_EN}
		== {wd_r[7], wd_r[5], wd_r[1]}) else $error("config write lost");
	AST_WR_LINK: assert property (REG_WR && REG_ADDR == 8'h5b |=>
		CABLE_TYPE_SELECT == wd_r[7]) else $error("cable bit write lost");
	AST_WR_ADDR: assert property (REG_WR && REG_ADDR == 8'h5f |=>
		REMOTE_ID_ADDR == wd_r) else $error("remote address write lost");
	AST_RD_CFG: assert property (REG_RD && REG_ADDR == 8'h54 |=>
		{REG_RDATA[7], REG_RDATA[5], REG_RDATA[1]} == {$past(EXTERNAL_CONTROL_OVERRIDE),
		$past(REMOTE_DISPLAY_ID_COPY), $past(AUX_AUDIO_EN)}) else $error("read wrong");
	AST_HOLD: assert property (STRAP_DONE && !REG_WR |=> $stable({DISPLAY_ID_SOURCE,
		AUX_AUDIO_EN, EXTERNAL_CONTROL_OVERRIDE, CABLE_TYPE_SELECT,
		REMOTE_DISPLAY_ID_COPY})) else $error("setting changed unwritten");
	cover property ($rose(STRAP_DONE));
	cover property (REG_WR && REG_ADDR == 8'h54);
	cover property (REG_RD && REG_ADDR == 8'h5b);
endmodule : smcl_checker
`default_nettype wire

//--- dv/smcl_strap_model.sv
// Board strap dividers: printed level number to comparator index.
// Assumes the bench sets levels 1..4 and 1..8.
`timescale 1ns/1ps
`default_nettype none
module smcl_strap_model (
	input wire logic [3:0] level0,
	input wire logic [3:0] level1,
	output logic [1:0] idx0,
	output logic [2:0] idx1
);
	// Divider ratio rises with level, so the index is level minus one
	assign idx0 = 2'(level0 - 4'h1);
	assign idx1 = 3'(level1 - 4'h1);
endmodule : smcl_strap_model
`default_nettype wire

//--- dv/smcl_tb.sv
// Self-checking bench for the strap mode configuration latch.
// Assumes package, design, strap model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import smcl_pkg::*;
	localparam int SETTLE = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [3:0] lv0 = 4'h1;
	logic [3:0] lv1 = 4'h1;
	logic [1:0] idx0;
	logic [2:0] idx1;
	logic [7:0] rdata;
	logic [7:0] raddr;
	logic done, src, aux, ext, cab, cpy;
	int fails = 0;
	int checks_done = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	smcl_strap_model board (.level0(lv0), .level1(lv1), .idx0(idx0),
		.idx1(idx1));
	smcl_top #(.SETTLE_CYC(SETTLE)) dut (.CORE_CLK(clk), .RST(rst),
		.MODE_SEL0_LEVEL(idx0), .MODE_SEL1_LEVEL(idx1), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.STRAP_DONE(done), .DISPLAY_ID_SOURCE(src), .AUX_AUDIO_EN(aux),
		.EXTERNAL_CONTROL_OVERRIDE(ext), .CABLE_TYPE_SELECT(cab),
		.REMOTE_DISPLAY_ID_COPY(cpy), .REMOTE_ID_ADDR(raddr));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One strobe cycle; read data is settled by the following falling edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask : bus
	task automatic power_up(input logic [3:0] l0, input logic [3:0] l1);
		int n;
		@(negedge clk);
		lv0 = l0;
		lv1 = l1;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		chk(raddr, 8'ha0);
		chk({2'h0, done, src, aux, ext, cab, cpy}, 8'h00);
		rst = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (done !== 1'b1) begin
			fails++;
			$display("Error at %0t: strap capture timed out", $time);
			complete_run();
		end
		// Capture one edge after the settle count ends
		chk(8'(n), 8'(SETTLE + 1));
	endtask : power_up
	task automatic strap_sweep();
		logic [1:0] e0;
		logic [2:0] e1;
		for (int k = 1; k <= 8; k++) begin
			e0 = 2'((k - 1) % 4);
			e1 = 3'(k - 1);
			power_up(4'(e0) + 4'h1, 4'(k));
			chk({6'h0, src, aux}, {6'h0, e0});
			chk({5'h0, ext, cab, cpy}, {5'h0, e1});
			bus(1'b0, 8'h4f, 8'h00);
			chk(rdata, {7'h0, e0[1]});
			bus(1'b0, 8'h54, 8'h00);
			chk(rdata, {e1[2], 1'b0, e1[0], 3'h0, e0[0], 1'b0});
			bus(1'b0, 8'h5b, 8'h00);
			chk(rdata, {e1[1], 7'h0});
		end
	endtask : strap_sweep
	// Starts from all-ones settings left by the last sweep step
	task automatic sw_override();
		lv0 = 4'h1;
		lv1 = 4'h1;
		repeat (SETTLE + 4) @(negedge clk);
		chk({3'h0, src, aux, ext, cab, cpy}, 8'h1f);
		bus(1'b1, 8'h54, 8'h5d);
		chk({5'h0, ext, cpy, aux}, 8'h00);
		bus(1'b1, 8'h4f, 8'hfe);
		chk({7'h0, src}, 8'h00);
		bus(1'b1, 8'h5b, 8'h7f);
		chk({7'h0, cab}, 8'h00);
		bus(1'b0, 8'h54, 8'h00);
		chk(rdata, 8'h5d);
		bus(1'b1, 8'h5f, 8'h3c);
		chk(raddr, 8'h3c);
		bus(1'b0, 8'h10, 8'h00);
		chk(rdata, SMCL_RDATA_UNMAPPED);
		bus(1'b1, 8'h54, 8'ha2);
		chk({5'h0, ext, cpy, aux}, 8'h07);
	endtask : sw_override
	// Writes while the straps settle: capture replaces only the strapped
	// bits; the rest of the byte and the remote address stay as written
	task automatic early_write();
		int n;
		@(negedge clk);
		lv0 = 4'h3;
		lv1 = 4'h3;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		chk(raddr, 8'ha0);
		rst = 1'b0;
		bus(1'b1, 8'h54, 8'hff);
		bus(1'b1, 8'h5f, 8'h11);
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (done !== 1'b1) begin
			fails++;
			$display("Error at %0t: strap capture timed out", $time);
			complete_run();
		end
		chk({3'h0, src, aux, ext, cab, cpy}, 8'h12);
		bus(1'b0, 8'h54, 8'h00);
		chk(rdata, 8'h5d);
		bus(1'b0, 8'h5f, 8'h00);
		chk(rdata, 8'h11);
	endtask : early_write
	task automatic complete_run();
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		strap_sweep();
		sw_override();
		early_write();
		complete_run();
	end
endmodule : tb
bind smcl_top smcl_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);
`default_nettype wire
